// ### inc/akc_regs.svh
// register offsets, bit positions, reset values and timing counts of the kernel control shell
`ifndef AKC_REGS_SVH
`define AKC_REGS_SVH
`define AKC_OFS_CTRL      12'h000
`define AKC_OFS_GIE       12'h004
`define AKC_OFS_IER       12'h008
`define AKC_OFS_ISR       12'h00C
`define AKC_OFS_ARG_SCAL  12'h010
`define AKC_OFS_ARG_PTR_L 12'h018
`define AKC_OFS_ARG_PTR_H 12'h01C
`define AKC_BIT_START     0
`define AKC_BIT_DONE      1
`define AKC_BIT_IDLE      2
`define AKC_BIT_READY     3
`define AKC_BIT_CONT      4
`define AKC_BIT_EN        0
`define AKC_RST_WORD      32'h0000_0000
`define AKC_RESP_OKAY     2'h0
`define AKC_RESP_SLVERR   2'h2
`define AKC_RST_STAGES    2
`define AKC_RUN_CYCLES    8'h10
`endif

// ### inc/akc_pkg.sv
// types shared by the kernel control shell
package akc_pkg;
  typedef enum logic [1:0] {
    akc_exec_hs_type_none
  } akc_dummy_type;
  typedef enum {
    akc_st_idle,
    akc_st_busy,
    akc_st_wait_cont
  } akc_state_type;
  typedef logic [31:0] akc_word_type;
  typedef logic [63:0] akc_ptr_type;
endpackage : akc_pkg

// ### hdl/akc_shell.sv
// kernel control shell: control slave, control word, interrupt registers, arguments
// Notes on behaviour
// - primary clock runs all kernel logic
// - optional second clock domain, unused here
// - primary reset low, synchronous, pipelined inside; the flops here use it as an asynchronous reset
// - secondary reset low, pipelined in its domain
// - single active-high interrupt output
// - exactly one control slave port
// - memory master addresses are 64 bits
// - memory base offset from host-written register
// - masters use incrementing full-width bursts only
// - stream ports carry data one way
// - argument registers start at offset 0x10
// - control word bits: start, done, idle, ready, continue
// - host sets start; kernel clears at done
// - done set on completion, cleared on read
// - idle bit while not processing
// - ready bit when new input accepted
// - handshake and chained modes keep control word
// - interrupt needs global and source enable
// - status bit toggles on write of one
// - completion event sets interrupt status
// - scalar args 32 bits, pointers 64 bits
// - main clock serves slave and reset
`include "akc_regs.svh"

module akc_shell #(
  parameter bit         CHAINED    = 1'b0,
  parameter logic [7:0] RUN_CYCLES = `AKC_RUN_CYCLES
) (
  // primary clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // optional second clock domain
  input  wire logic                 second_clock_i,
  input  wire logic                 second_reset_low_i,
  // control slave, write channels
  input  wire logic [11:0]          s_axi_control_awaddr_i,
  input  wire logic                 s_axi_control_awvalid_i,
  output logic                      s_axi_control_awready_o,
  input  wire akc_pkg::akc_word_type s_axi_control_wdata_i,
  input  wire logic [3:0]           s_axi_control_wstrb_i,
  input  wire logic                 s_axi_control_wvalid_i,
  output logic                      s_axi_control_wready_o,
  output logic [1:0]                s_axi_control_bresp_o,
  output logic                      s_axi_control_bvalid_o,
  input  wire logic                 s_axi_control_bready_i,
  // control slave, read channels
  input  wire logic [11:0]          s_axi_control_araddr_i,
  input  wire logic                 s_axi_control_arvalid_i,
  output logic                      s_axi_control_arready_o,
  output akc_pkg::akc_word_type     s_axi_control_rdata_o,
  output logic [1:0]                s_axi_control_rresp_o,
  output logic                      s_axi_control_rvalid_o,
  input  wire logic                 s_axi_control_rready_i,
  // argument values towards the datapath
  output akc_pkg::akc_word_type     arg_scalar_o,
  output akc_pkg::akc_ptr_type      arg_mem_base_o,
  // interrupt
  output logic                      interrupt_o
);
  import akc_pkg::*;

  // ************************************************************
  // reset pipeline
  // ************************************************************
  // the incoming reset is already synchronous; stages only ease fanout timing
  logic [`AKC_RST_STAGES-1:0] rst_pipe;
  logic [`AKC_RST_STAGES-1:0] rst2_pipe;
  logic                       rst_n;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= '0;
    end else begin
      rst_pipe <= {rst_pipe[`AKC_RST_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[`AKC_RST_STAGES-1];

  // second domain only pipelines its reset; no logic uses it yet
  always_ff @(posedge second_clock_i or negedge second_reset_low_i) begin
    if (!second_reset_low_i) begin
      rst2_pipe <= '0;
    end else begin
      rst2_pipe <= {rst2_pipe[`AKC_RST_STAGES-2:0], 1'b1};
    end
  end

  // ************************************************************
  // register state
  // ************************************************************
  akc_state_type state;
  logic          run_request;
  logic          run_finished;
  logic          keep_going;
  logic          global_irq_enable_bit;
  logic          source_irq_enable_bit;
  logic          irq_status;
  akc_word_type  arg_scalar;
  akc_ptr_type   arg_ptr;
  logic [7:0]    run_cnt;
  logic          finish_evt;
  logic          quiescent_flag;
  logic          accepts_new_input;

  // ************************************************************
  // control slave handshake (one outstanding access per direction)
  // ************************************************************
  logic         aw_held;
  logic         w_held;
  logic [11:0]  aw_addr;
  akc_word_type w_data;
  logic [3:0]   w_strb;
  logic         wr_fire;
  logic         rd_fire;

  assign s_axi_control_awready_o = !aw_held && !s_axi_control_bvalid_o;
  assign s_axi_control_wready_o  = !w_held && !s_axi_control_bvalid_o;
  assign s_axi_control_arready_o = !s_axi_control_rvalid_o;
  assign wr_fire = aw_held && w_held && !s_axi_control_bvalid_o;
  assign rd_fire = s_axi_control_arvalid_i && s_axi_control_arready_o;

  // address and data may come in either order; hold each until both are in
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= `AKC_RST_WORD;
      w_strb  <= '0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_control_awvalid_i && s_axi_control_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_control_awaddr_i;
      end
      if (s_axi_control_wvalid_i && s_axi_control_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_control_wdata_i;
        w_strb <= s_axi_control_wstrb_i;
      end
    end
  end

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `AKC_OFS_CTRL) || (a == `AKC_OFS_GIE) || (a == `AKC_OFS_IER) ||
                  (a == `AKC_OFS_ISR) || (a == `AKC_OFS_ARG_SCAL) ||
                  (a == `AKC_OFS_ARG_PTR_L) || (a == `AKC_OFS_ARG_PTR_H);
  endfunction : addr_mapped

  // byte-lane merge used by the three argument words
  function automatic akc_word_type merge(input akc_word_type old_v, input akc_word_type new_v,
                                         input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction : merge

  logic wr_ctrl;
  logic wr_low;
  assign wr_ctrl = wr_fire && (aw_addr == `AKC_OFS_CTRL) && w_strb[0];
  assign wr_low  = w_strb[0];

  // write response
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_control_bvalid_o <= 1'b0;
      s_axi_control_bresp_o  <= `AKC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_control_bvalid_o <= 1'b1;
      s_axi_control_bresp_o  <= addr_mapped(aw_addr) ? `AKC_RESP_OKAY : `AKC_RESP_SLVERR;
    end else if (s_axi_control_bready_i) begin
      s_axi_control_bvalid_o <= 1'b0;
    end
  end

  // ************************************************************
  // enable, status and argument registers
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_irq_enable_bit <= 1'b0;
      source_irq_enable_bit <= 1'b0;
      arg_scalar            <= `AKC_RST_WORD;
      arg_ptr               <= '0;
    end else if (wr_fire) begin
      if (aw_addr == `AKC_OFS_GIE && wr_low)
        global_irq_enable_bit <= w_data[`AKC_BIT_EN];
      if (aw_addr == `AKC_OFS_IER && wr_low)
        source_irq_enable_bit <= w_data[`AKC_BIT_EN];
      if (aw_addr == `AKC_OFS_ARG_SCAL)
        arg_scalar <= merge(arg_scalar, w_data, w_strb);
      if (aw_addr == `AKC_OFS_ARG_PTR_L)
        arg_ptr[31:0] <= merge(arg_ptr[31:0], w_data, w_strb);
      if (aw_addr == `AKC_OFS_ARG_PTR_H)
        arg_ptr[63:32] <= merge(arg_ptr[63:32], w_data, w_strb);
    end
  end

  // status toggles on a written one; a completion in that cycle still sets it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status <= 1'b0;
    end else if (finish_evt) begin
      irq_status <= 1'b1;
    end else if (wr_fire && aw_addr == `AKC_OFS_ISR && wr_low && w_data[`AKC_BIT_EN]) begin
      irq_status <= !irq_status;
    end
  end

  // registered output keeps the interrupt glitch free
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interrupt_o <= 1'b0;
    end else begin
      interrupt_o <= global_irq_enable_bit && source_irq_enable_bit && irq_status;
    end
  end

  // ************************************************************
  // run sequencer: stands in for the datapath with a fixed run length
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= akc_st_idle;
      run_cnt <= '0;
    end else if (!rst_n) begin
      state   <= akc_st_idle;
      run_cnt <= '0;
    end else begin
      unique case (state)
        akc_st_idle: begin
          if (run_request) begin
            state   <= akc_st_busy;
            run_cnt <= RUN_CYCLES;
          end
        end
        akc_st_busy: begin
          run_cnt <= run_cnt - 8'h01;
          if (run_cnt == 8'h01)
            state <= (CHAINED && !keep_going) ? akc_st_wait_cont : akc_st_idle;
        end
        akc_st_wait_cont: begin
          if (keep_going)
            state <= akc_st_idle;
        end
      endcase
    end
  end

  assign finish_evt        = (state == akc_st_busy) && (run_cnt == 8'h01);
  assign quiescent_flag    = (state == akc_st_idle);
  assign accepts_new_input = (state == akc_st_idle) && !run_request;

  // control word: start set by host, cleared by the kernel at completion
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_request  <= 1'b0;
      run_finished <= 1'b0;
      keep_going   <= 1'b0;
    end else begin
      if (finish_evt)
        run_request <= 1'b0;
      else if (wr_ctrl && w_data[`AKC_BIT_START])
        run_request <= 1'b1;
      if (finish_evt)
        run_finished <= 1'b1;
      else if (rd_fire && s_axi_control_araddr_i == `AKC_OFS_CTRL)
        run_finished <= 1'b0;
      if (wr_ctrl && w_data[`AKC_BIT_CONT])
        keep_going <= 1'b1;
      else if (state == akc_st_wait_cont && keep_going)
        keep_going <= 1'b0;
    end
  end

  // ************************************************************
  // read data path
  // ************************************************************
  akc_word_type next_rdata;
  always_comb begin
    next_rdata = `AKC_RST_WORD;
    unique case (s_axi_control_araddr_i)
      `AKC_OFS_CTRL: begin
        next_rdata[`AKC_BIT_START] = run_request;
        next_rdata[`AKC_BIT_DONE]  = run_finished;
        next_rdata[`AKC_BIT_IDLE]  = quiescent_flag;
        next_rdata[`AKC_BIT_READY] = accepts_new_input;
        next_rdata[`AKC_BIT_CONT]  = keep_going;
      end
      `AKC_OFS_GIE:       next_rdata[`AKC_BIT_EN] = global_irq_enable_bit;
      `AKC_OFS_IER:       next_rdata[`AKC_BIT_EN] = source_irq_enable_bit;
      `AKC_OFS_ISR:       next_rdata[`AKC_BIT_EN] = irq_status;
      `AKC_OFS_ARG_SCAL:  next_rdata = arg_scalar;
      `AKC_OFS_ARG_PTR_L: next_rdata = arg_ptr[31:0];
      `AKC_OFS_ARG_PTR_H: next_rdata = arg_ptr[63:32];
      default:            next_rdata = `AKC_RST_WORD;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_control_rvalid_o <= 1'b0;
      s_axi_control_rdata_o  <= `AKC_RST_WORD;
      s_axi_control_rresp_o  <= `AKC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_control_rvalid_o <= 1'b1;
      s_axi_control_rdata_o  <= next_rdata;
      s_axi_control_rresp_o  <= addr_mapped(s_axi_control_araddr_i) ?
                                `AKC_RESP_OKAY : `AKC_RESP_SLVERR;
    end else if (s_axi_control_rready_i) begin
      s_axi_control_rvalid_o <= 1'b0;
    end
  end

  // argument outputs come straight from their flops
  assign arg_scalar_o   = arg_scalar;
  assign arg_mem_base_o = arg_ptr; // masters and streams sit in the datapath
endmodule : akc_shell

// ### verification/akc_shell_asserts.sv
// concurrent checks of the kernel control shell at its ports
`include "akc_regs.svh"
module akc_shell_asserts (
  input wire logic                  sys_clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  s_axi_control_awvalid_i,
  input wire logic                  s_axi_control_awready_o,
  input wire logic                  s_axi_control_wvalid_i,
  input wire logic                  s_axi_control_wready_o,
  input wire logic                  s_axi_control_bvalid_o,
  input wire logic                  s_axi_control_bready_i,
  input wire logic                  s_axi_control_arvalid_i,
  input wire logic                  s_axi_control_arready_o,
  input wire logic [11:0]           s_axi_control_araddr_i,
  input wire logic                  s_axi_control_rvalid_o,
  input wire logic                  s_axi_control_rready_i,
  input wire logic [1:0]            s_axi_control_rresp_o,
  input wire akc_pkg::akc_word_type s_axi_control_rdata_o,
  input wire logic                  interrupt_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // handshake, response and interrupt checks
  // ****************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // answers stand until taken
  property p_b_hold; s_axi_control_bvalid_o && !s_axi_control_bready_i |=> s_axi_control_bvalid_o;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_r_hold;
    s_axi_control_rvalid_o && !s_axi_control_rready_i |=>
      s_axi_control_rvalid_o && $stable(s_axi_control_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer changed early");
  property p_w_ans;
    s_axi_control_awvalid_i && s_axi_control_awready_o && s_axi_control_wvalid_i &&
      s_axi_control_wready_o |-> ##[1:3] s_axi_control_bvalid_o;
  endproperty
  a_w_ans: assert property (p_w_ans) else $error("write not answered");
  property p_r_ans; s_axi_control_arvalid_i && s_axi_control_arready_o |=> s_axi_control_rvalid_o;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read not answered");
  // no new request taken while an answer is pending
  property p_b_busy; s_axi_control_bvalid_o |-> !s_axi_control_awready_o && !s_axi_control_wready_o;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while answer pending");
  property p_r_busy; s_axi_control_rvalid_o |-> !s_axi_control_arready_o; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken while answer pending");
  // nothing lives above the argument block
  property p_rd_err;
    s_axi_control_arvalid_i && s_axi_control_arready_o && s_axi_control_araddr_i >= 12'h020 |=>
      s_axi_control_rresp_o == `AKC_RESP_SLVERR && s_axi_control_rdata_o == 32'h0000_0000;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  property p_rd_ok;
    s_axi_control_arvalid_i && s_axi_control_arready_o && s_axi_control_araddr_i < 12'h010 &&
      s_axi_control_araddr_i[1:0] == 2'h0 |=> s_axi_control_rresp_o == `AKC_RESP_OKAY;
  endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("standard register read refused");
  // the line only drops after a host write has landed
  property p_irq_fall;
    $fell(interrupt_o) |-> $past(s_axi_control_bvalid_o) || $past(s_axi_control_bvalid_o, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
  c_wr: cover property (s_axi_control_bvalid_o && s_axi_control_bready_i);
  c_err: cover property (s_axi_control_rvalid_o && s_axi_control_rresp_o == `AKC_RESP_SLVERR);
  c_irq: cover property ($rose(interrupt_o));
endmodule : akc_shell_asserts

bind akc_shell akc_shell_asserts u_chk (.*);

// ### verification/akc_host_model.sv
// host-side model: drives the control slave the way the runtime does
module akc_host_model (
  // clock
  input  wire logic                  sys_clk_i,
  // requests towards the shell
  output logic [11:0]                s_axi_control_awaddr_i, s_axi_control_araddr_i,
  output akc_pkg::akc_word_type      s_axi_control_wdata_i,
  output logic [3:0]                 s_axi_control_wstrb_i,
  output logic                       s_axi_control_awvalid_i, s_axi_control_wvalid_i,
  output logic                       s_axi_control_bready_i, s_axi_control_arvalid_i,
  output logic                       s_axi_control_rready_i,
  // answers from the shell
  input  wire logic                  s_axi_control_awready_o, s_axi_control_wready_o,
  input  wire logic                  s_axi_control_bvalid_o, s_axi_control_arready_o,
  input  wire logic                  s_axi_control_rvalid_o,
  input  wire logic [1:0]            s_axi_control_bresp_o, s_axi_control_rresp_o,
  input  wire akc_pkg::akc_word_type s_axi_control_rdata_o
);
  import akc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero; full-word writes only
  initial begin
    {s_axi_control_awvalid_i, s_axi_control_wvalid_i, s_axi_control_arvalid_i} = 3'h0;
    {s_axi_control_bready_i, s_axi_control_rready_i} = 2'h0;
    {s_axi_control_awaddr_i, s_axi_control_araddr_i, s_axi_control_wdata_i} = '0;
    s_axi_control_wstrb_i = 4'hF;
  end
  // one write; the answer is left waiting a cycle so the slave must hold it
  task automatic wr(input logic [11:0] a, input akc_word_type d, output logic [1:0] rsp);
    logic ka, kw;
    ka = 1'b0;
    kw = 1'b0;
    s_axi_control_awaddr_i <= a;
    s_axi_control_wdata_i <= d;
    s_axi_control_awvalid_i <= 1'b1;
    s_axi_control_wvalid_i <= 1'b1;
    for (int n = 0; n < 20 && !(ka && kw); n++) begin
      #1;
      ka = ka | s_axi_control_awready_o;
      kw = kw | s_axi_control_wready_o;
      @(negedge sys_clk_i);
      // released lines show the inverse, never a stale copy
      if (ka) begin
        s_axi_control_awvalid_i <= 1'b0;
        s_axi_control_awaddr_i <= ~a;
      end
      if (kw) begin
        s_axi_control_wvalid_i <= 1'b0;
        s_axi_control_wdata_i <= ~d;
      end
    end
    for (int n = 0; n < 20 && !s_axi_control_bvalid_o; n++) @(negedge sys_clk_i);
    rsp = s_axi_control_bresp_o;
    @(negedge sys_clk_i) s_axi_control_bready_i <= 1'b1;
    @(negedge sys_clk_i) s_axi_control_bready_i <= 1'b0;
  endtask : wr
  // one read, answer likewise held back a cycle
  task automatic rd(input logic [11:0] a, output akc_word_type d, output logic [1:0] rsp);
    logic k;
    k = 1'b0;
    s_axi_control_araddr_i <= a;
    s_axi_control_arvalid_i <= 1'b1;
    for (int n = 0; n < 20 && !k; n++) begin
      #1;
      k = s_axi_control_arready_o;
      @(negedge sys_clk_i);
    end
    s_axi_control_arvalid_i <= 1'b0;
    s_axi_control_araddr_i <= ~a;
    for (int n = 0; n < 20 && !s_axi_control_rvalid_o; n++) @(negedge sys_clk_i);
    d = s_axi_control_rdata_o;
    rsp = s_axi_control_rresp_o;
    @(negedge sys_clk_i) s_axi_control_rready_i <= 1'b1;
    @(negedge sys_clk_i) s_axi_control_rready_i <= 1'b0;
  endtask : rd
endmodule : akc_host_model

// ### verification/tb.sv
// self-checking bench of the kernel control shell
`include "akc_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import akc_pkg::*;
  // a short run keeps polling loops brief
  localparam logic [7:0] RUN = 8'h08;
  logic sys_clk_i, rst_n_i;
  logic [11:0] s_axi_control_awaddr_i, s_axi_control_araddr_i;
  akc_word_type s_axi_control_wdata_i, s_axi_control_rdata_o, arg_scalar_o, v;
  akc_ptr_type arg_mem_base_o;
  logic [3:0] s_axi_control_wstrb_i;
  logic [1:0] s_axi_control_bresp_o, s_axi_control_rresp_o, r;
  logic s_axi_control_awvalid_i, s_axi_control_wvalid_i, s_axi_control_bready_i;
  logic s_axi_control_arvalid_i, s_axi_control_rready_i, s_axi_control_awready_o;
  logic s_axi_control_wready_o, s_axi_control_bvalid_o, s_axi_control_arready_o;
  logic s_axi_control_rvalid_o, interrupt_o;
  wire logic second_clock_i = sys_clk_i;
  wire logic second_reset_low_i = rst_n_i;
  int n_errors, cmp_count;
  akc_shell #(.CHAINED(1'b0), .RUN_CYCLES(RUN)) u_dut (.*);
  akc_host_model u_host (.*);
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ************
  // common tasks
  // ************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // launch a run and poll until it reports finished
  task automatic run_wait(output akc_word_type c);
    u_host.wr(`AKC_OFS_CTRL, 32'h0000_0001, r);
    u_host.rd(`AKC_OFS_CTRL, c, r);
    chk({c[`AKC_BIT_IDLE], c[`AKC_BIT_START]}, 2'b01);
    for (int n = 0; n < 30 && !c[`AKC_BIT_DONE]; n++) u_host.rd(`AKC_OFS_CTRL, c, r);
    chk(c[2:0], 3'h6);
    chk(c[31:5], 27'h0);
  endtask : run_wait
  task automatic t_reset();
    u_host.rd(`AKC_OFS_CTRL, v, r);
    chk(v[3:0], 4'hC);
    for (int a = 4; a < 16; a += 4) begin
      u_host.rd(12'(a), v, r);
      chk({r, v}, {`AKC_RESP_OKAY, `AKC_RST_WORD});
    end
    u_host.rd(12'h014, v, r);
    chk({r, v}, {`AKC_RESP_SLVERR, 32'h0});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_irq();
    u_host.wr(`AKC_OFS_GIE, 32'h1, r);
    u_host.wr(`AKC_OFS_IER, 32'h1, r);
    run_wait(v);
    repeat (3) @(negedge sys_clk_i);
    chk(interrupt_o, 1'b1);
    u_host.rd(`AKC_OFS_CTRL, v, r);
    chk(v[`AKC_BIT_DONE], 1'b0);
    u_host.wr(`AKC_OFS_ISR, 32'h1, r);
    repeat (3) @(negedge sys_clk_i);
    chk(interrupt_o, 1'b0);
    u_host.rd(`AKC_OFS_ISR, v, r);
    chk(v, 32'h0);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_mask();
    u_host.wr(`AKC_OFS_GIE, 32'h0, r);
    run_wait(v);
    repeat (3) @(negedge sys_clk_i);
    chk(interrupt_o, 1'b0);
    u_host.rd(`AKC_OFS_ISR, v, r);
    chk(v, 32'h1);
    u_host.wr(`AKC_OFS_GIE, 32'h1, r);
    repeat (3) @(negedge sys_clk_i);
    chk(interrupt_o, 1'b1);
    u_host.wr(`AKC_OFS_ISR, 32'h1, r);
    $display("t_mask done");
  endtask : t_mask
  task automatic t_args();
    u_host.wr(`AKC_OFS_ARG_SCAL, 32'hA5C3_0F01, r);
    u_host.wr(`AKC_OFS_ARG_PTR_L, 32'h8765_4321, r);
    u_host.wr(`AKC_OFS_ARG_PTR_H, 32'h1234_5678, r);
    chk(arg_mem_base_o, 64'h1234_5678_8765_4321);
    u_host.rd(`AKC_OFS_ARG_SCAL, v, r);
    chk({v, arg_scalar_o}, {32'hA5C3_0F01, 32'hA5C3_0F01});
    u_host.wr(12'h020, 32'h1, r);
    chk(r, `AKC_RESP_SLVERR);
    u_host.rd(12'h020, v, r);
    chk({r, v}, {`AKC_RESP_SLVERR, 32'h0});
    // host grants further iterations; the bit reads back while the kernel rests
    u_host.wr(`AKC_OFS_CTRL, 32'h0000_0010, r);
    u_host.rd(`AKC_OFS_CTRL, v, r);
    chk(v[4:0], 5'h1C);
    $display("t_args done");
  endtask : t_args
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    n_errors = 0;
    cmp_count = 0;
    rst_n_i = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    t_reset();
    t_irq();
    t_mask();
    t_args();
    stop_test();
  end
endmodule : tb
